// ### csso_pkg.sv
package csso_pkg;

   // ==========================================================
   // timing
   localparam int unsigned CLK_PERIOD_NS  = 100;
   localparam int unsigned TICK_PERIOD_NS = 1000000;
   localparam int unsigned TICK_DIV       = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned INIT_TIME_MS   = 6000;
   localparam int unsigned INIT_TICKS     =
      INIT_TIME_MS * 1000 / (TICK_PERIOD_NS / 1000);
   localparam int unsigned DIV_W          = 16;
   localparam int unsigned CNT_W          = 16;

   // ==========================================================
   // frame layout and identifiers
   localparam logic [10:0] SDO_RX_BASE = 11'h600;
   localparam logic [10:0] SDO_TX_BASE = 11'h580;
   localparam logic [3:0]  SDO_DLC     = 4'h8;
   localparam logic [7:0]  NODE_MAX    = 8'h7F;

   // ==========================================================
   // command bytes
   localparam logic [7:0] CMD_WR8    = 8'h2F;
   localparam logic [7:0] CMD_WR16   = 8'h2B;
   localparam logic [7:0] CMD_WR32   = 8'h23;
   localparam logic [7:0] CMD_WR_ACK = 8'h60;
   localparam logic [7:0] CMD_RD_REQ = 8'h40;
   localparam logic [7:0] CMD_RD8    = 8'h4F;
   localparam logic [7:0] CMD_RD16   = 8'h4B;
   localparam logic [7:0] CMD_RD32   = 8'h43;
   localparam logic [7:0] CMD_ABORT  = 8'h80;

   // ==========================================================
   // abort codes
   localparam logic [31:0] ABT_READ_ONLY = 32'h06010002;
   localparam logic [31:0] ABT_NO_OBJECT = 32'h06020000;
   localparam logic [31:0] ABT_BAD_CMD   = 32'h05040001;

   // ==========================================================
   // object sizes
   localparam logic [1:0] SZ8  = 2'h0;
   localparam logic [1:0] SZ16 = 2'h1;
   localparam logic [1:0] SZ32 = 2'h2;

   // ==========================================================
   // types
   typedef enum logic [1:0] {NMT_INIT, NMT_PREOP, NMT_OPER, NMT_STOP}
      csso_nmt_e;
   typedef enum logic [1:0] {SDO_IDLE, SDO_LOOK, SDO_SEND} csso_sdo_e;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             tick;
   } csso_tick_s;

   typedef struct packed {
      csso_nmt_e        nmt;
      csso_sdo_e        sdo;
      logic [CNT_W-1:0] ms_cnt;
      logic             emcy;
      logic             pdo_all;
      logic [7:0]       node_s1;
      logic [7:0]       node_s2;
      logic [3:0]       rate_s1;
      logic [3:0]       rate_s2;
      logic             auto_s1;
      logic             auto_s2;
      logic [6:0]       node;
      logic [3:0]       rate;
      logic             we;
      logic [15:0]      idx;
      logic [7:0]       sub;
      logic [31:0]      wdata;
      logic             od_wr;
      logic [10:0]      tx_id;
      logic [63:0]      tx_data;
   } csso_st_s;

endpackage

// ### csso_tick.sv
`timescale 1ns/1ps
module csso_tick
   import csso_pkg::*;
#(
   parameter int unsigned DIV = csso_pkg::TICK_DIV
) (
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   // control
   input  wire logic restart_i,
   // enable pulse
   output logic      tick_o
);

   csso_tick_s q, d;

   // ==========================================================
   // divider: one-cycle pulse every DIV clocks
   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (restart_i) begin
         d.cnt = '0;
      end else if (q.cnt == DIV_W'(DIV - 1)) begin
         d.cnt  = '0;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 1'b1;
      end
   end

   // state register
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick_o = q.tick;

endmodule

// ### csso_top.sv
`timescale 1ns/1ps
// Summary of operation
// - enter pre-operational five to ten seconds after power-on
// - send one emergency on entering pre-operational from initialisation
// - serve SDO only in pre-operational or operational
// - process data disabled until operational
// - send all transmit PDOs once entering operational
// - reads always allowed, writes only read/write objects
// - standard frames with 11 bit identifiers
// - requests 0x600 plus node, answers 0x580 plus node
// - every SDO frame carries eight data bytes
// - frame carries index, subindex, length and value
// - bytes two, three, four: index low, high, subindex
// - optional automatic bit rate detection at start
// - write acknowledge carries four zero payload bytes
// - read 40; answer 4F, 4B or 43 by size
module csso_top
   import csso_pkg::*;
#(
   parameter int unsigned TICK_CYC   = csso_pkg::TICK_DIV,
   parameter int unsigned INIT_TICKS = csso_pkg::INIT_TICKS
) (
   // clock and reset
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_i,
   // straps and bit rate detector
   input  wire logic [7:0]           node_sw_i,
   input  wire logic [3:0]           rate_sw_i,
   input  wire logic                 auto_rate_i,
   input  wire logic                 det_valid_i,
   input  wire logic [3:0]           det_rate_i,
   // network management commands
   input  wire logic                 nmt_start_i,
   input  wire logic                 nmt_preop_i,
   input  wire logic                 nmt_stop_i,
   input  wire logic                 nmt_reset_i,
   // received frame
   input  wire logic                 rx_valid_i,
   input  wire logic                 rx_ide_i,
   input  wire logic [10:0]          rx_id_i,
   input  wire logic [3:0]           rx_dlc_i,
   input  wire logic [63:0]          rx_data_i,
   // transmitted frame
   output logic                      tx_valid_o,
   input  wire logic                 tx_ready_i,
   output logic [10:0]               tx_id_o,
   output logic [3:0]                tx_dlc_o,
   output logic [63:0]               tx_data_o,
   // object dictionary
   output logic                      od_req_o,
   output logic [15:0]               od_index_o,
   output logic [7:0]                od_sub_o,
   input  wire logic                 od_ack_i,
   input  wire logic                 od_exist_i,
   input  wire logic                 od_rw_i,
   input  wire logic [1:0]           od_size_i,
   input  wire logic [31:0]          od_rdata_i,
   output logic                      od_wr_o,
   output logic [31:0]               od_wdata_o,
   // status and events
   output csso_pkg::csso_nmt_e       nmt_state_o,
   output logic [6:0]                node_id_o,
   output logic [3:0]                bitrate_o,
   output logic                      emcy_req_o,
   output logic                      pdo_en_o,
   output logic                      pdo_send_all_o
);

   csso_st_s q, d;
   logic     tick;
   logic     restart;
   logic     sdo_ok;
   logic     rx_hit;
   logic     node_ok;

   // ==========================================================
   // helpers
   // clear bytes beyond the object size
   function automatic logic [31:0] fit(input logic [31:0] v,
                                       input logic [1:0]  sz);
      if (sz == SZ8) begin
         return {24'h000000, v[7:0]};
      end else if (sz == SZ16) begin
         return {16'h0000, v[15:0]};
      end
      return v;
   endfunction

   // assemble answer: command, index, subindex, payload
   function automatic logic [63:0] frame(input logic [7:0]  cmd,
                                         input logic [15:0] idx,
                                         input logic [7:0]  sub,
                                         input logic [31:0] val);
      return {val, sub, idx, cmd};
   endfunction

   // ==========================================================
   // millisecond enable
   csso_tick #(
      .DIV       (TICK_CYC)
   ) u_tick (
      .core_clk_i(core_clk_i),
      .rst_i     (rst_i),
      .restart_i (restart),
      .tick_o    (tick)
   );

   // ==========================================================
   // request qualification
   assign node_ok = (q.node_s2 != 8'h00) && (q.node_s2 <= NODE_MAX);
   assign sdo_ok  = (q.nmt == NMT_PREOP) || (q.nmt == NMT_OPER);
   assign rx_hit  = rx_valid_i && !rx_ide_i
                  && (rx_id_i == SDO_RX_BASE + {4'h0, q.node})
                  && (rx_dlc_i == SDO_DLC);
   assign restart = (q.nmt != NMT_INIT) && nmt_reset_i;

   // ==========================================================
   // next state
   always_comb begin
      d = q;
      d.node_s1 = node_sw_i;
      d.node_s2 = q.node_s1;
      d.rate_s1 = rate_sw_i;
      d.rate_s2 = q.rate_s1;
      d.auto_s1 = auto_rate_i;
      d.auto_s2 = q.auto_s1;
      d.emcy    = 1'b0;
      d.pdo_all = 1'b0;
      d.od_wr   = 1'b0;
      // network state; resets are ignored while initialising
      unique case (q.nmt)
         NMT_INIT: begin
            if (tick) begin
               if (q.ms_cnt == CNT_W'(INIT_TICKS - 1)) begin
                  if (node_ok) begin
                     d.nmt  = NMT_PREOP;
                     d.emcy = 1'b1;
                     d.node = q.node_s2[6:0];
                     d.rate = (q.auto_s2 && det_valid_i)
                            ? det_rate_i : q.rate_s2;
                  end
               end else begin
                  d.ms_cnt = q.ms_cnt + 1'b1;
               end
            end
         end
         NMT_PREOP, NMT_OPER, NMT_STOP: begin
            if (nmt_reset_i) begin
               d.nmt    = NMT_INIT;
               d.ms_cnt = '0;
            end else if (nmt_start_i && q.nmt != NMT_OPER) begin
               d.nmt     = NMT_OPER;
               d.pdo_all = 1'b1;
            end else if (nmt_preop_i) begin
               d.nmt = NMT_PREOP;
            end else if (nmt_stop_i) begin
               d.nmt = NMT_STOP;
            end
         end
      endcase
      // SDO server
      unique case (q.sdo)
         SDO_IDLE: begin
            if (sdo_ok && rx_hit) begin
               d.idx   = rx_data_i[23:8];
               d.sub   = rx_data_i[31:24];
               d.tx_id = SDO_TX_BASE + {4'h0, q.node};
               d.sdo   = SDO_LOOK;
               unique case (rx_data_i[7:0])
                  CMD_WR8: begin
                     d.we    = 1'b1;
                     d.wdata = fit(rx_data_i[63:32], SZ8);
                  end
                  CMD_WR16: begin
                     d.we    = 1'b1;
                     d.wdata = fit(rx_data_i[63:32], SZ16);
                  end
                  CMD_WR32: begin
                     d.we    = 1'b1;
                     d.wdata = rx_data_i[63:32];
                  end
                  CMD_RD_REQ: begin
                     d.we = 1'b0;
                  end
                  default: begin
                     d.sdo     = SDO_SEND;
                     d.tx_data = frame(CMD_ABORT, rx_data_i[23:8],
                                       rx_data_i[31:24], ABT_BAD_CMD);
                  end
               endcase
            end
         end
         SDO_LOOK: begin
            if (od_ack_i) begin
               d.sdo = SDO_SEND;
               if (!od_exist_i) begin
                  d.tx_data = frame(CMD_ABORT, q.idx, q.sub,
                                    ABT_NO_OBJECT);
               end else if (q.we && !od_rw_i) begin
                  d.tx_data = frame(CMD_ABORT, q.idx, q.sub,
                                    ABT_READ_ONLY);
               end else if (q.we) begin
                  d.od_wr   = 1'b1;
                  d.tx_data = frame(CMD_WR_ACK, q.idx, q.sub,
                                    32'h00000000);
               end else if (od_size_i == SZ8) begin
                  d.tx_data = frame(CMD_RD8, q.idx, q.sub,
                                    fit(od_rdata_i, SZ8));
               end else if (od_size_i == SZ16) begin
                  d.tx_data = frame(CMD_RD16, q.idx, q.sub,
                                    fit(od_rdata_i, SZ16));
               end else begin
                  d.tx_data = frame(CMD_RD32, q.idx, q.sub, od_rdata_i);
               end
            end
         end
         SDO_SEND: begin
            if (tx_ready_i) begin
               d.sdo = SDO_IDLE;
            end
         end
         default: begin
            d.sdo = SDO_IDLE;
         end
      endcase
      // leaving pre-operational or operational drops any transfer in flight
      if (d.nmt != NMT_PREOP && d.nmt != NMT_OPER) begin
         d.sdo   = SDO_IDLE;
         d.od_wr = 1'b0;
      end
   end

   // state register
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // outputs
   assign tx_valid_o     = (q.sdo == SDO_SEND);
   assign tx_id_o        = q.tx_id;
   assign tx_dlc_o       = SDO_DLC;
   assign tx_data_o      = q.tx_data;
   assign od_req_o       = (q.sdo == SDO_LOOK);
   assign od_index_o     = q.idx;
   assign od_sub_o       = q.sub;
   assign od_wr_o        = q.od_wr;
   assign od_wdata_o     = q.wdata;
   assign nmt_state_o    = q.nmt;
   assign node_id_o      = q.node;
   assign bitrate_o      = q.rate;
   assign emcy_req_o     = q.emcy;
   assign pdo_en_o       = (q.nmt == NMT_OPER);
   assign pdo_send_all_o = q.pdo_all;

   // ==========================================================
   // assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_rd_accept;
      q.sdo == SDO_IDLE && sdo_ok && rx_hit
         && rx_data_i[7:0] == CMD_RD_REQ
         && !nmt_reset_i && !nmt_stop_i;
   endsequence
   sequence s_lookup;
      od_req_o && od_index_o == $past(rx_data_i[23:8])
         && od_sub_o == $past(rx_data_i[31:24]);
   endsequence

   property p_init_len;
      (nmt_state_o == NMT_PREOP && $past(nmt_state_o) == NMT_INIT)
         |-> $past(q.ms_cnt) == CNT_W'(INIT_TICKS - 1);
   endproperty
   a_init_len: assert property (p_init_len)
      else $error("pre-operational entered before init time");

   property p_emcy;
      emcy_req_o |-> nmt_state_o == NMT_PREOP
         && $past(nmt_state_o) == NMT_INIT ##1 !emcy_req_o;
   endproperty
   a_emcy: assert property (p_emcy)
      else $error("emergency not a single pulse at pre-op entry");

   property p_sdo_state;
      tx_valid_o || od_req_o |-> nmt_state_o inside {NMT_PREOP, NMT_OPER};
   endproperty
   a_sdo_state: assert property (p_sdo_state)
      else $error("SDO served outside pre-op or operational");

   property p_pdo_off;
      nmt_state_o != NMT_OPER |-> !pdo_en_o && !pdo_send_all_o;
   endproperty
   a_pdo_off: assert property (p_pdo_off)
      else $error("process data active outside operational");

   property p_pdo_all;
      $rose(pdo_en_o) |-> pdo_send_all_o ##1 !pdo_send_all_o;
   endproperty
   a_pdo_all: assert property (p_pdo_all)
      else $error("transmit PDOs not requested once on start");

   property p_wr_ro;
      od_wr_o |-> $past(od_ack_i) && $past(od_rw_i) && $past(od_exist_i);
   endproperty
   a_wr_ro: assert property (p_wr_ro)
      else $error("write issued to a read-only object");

   property p_ext_ignored;
      rx_valid_i && rx_ide_i && q.sdo == SDO_IDLE |=> q.sdo == SDO_IDLE;
   endproperty
   a_ext_ignored: assert property (p_ext_ignored)
      else $error("extended frame accepted");

   property p_tx_frame;
      tx_valid_o |-> tx_dlc_o == SDO_DLC
         && tx_id_o == SDO_TX_BASE + {4'h0, node_id_o};
   endproperty
   a_tx_frame: assert property (p_tx_frame)
      else $error("answer identifier or length wrong");

   property p_index;
      s_rd_accept |=> s_lookup;
   endproperty
   a_index: assert property (p_index)
      else $error("index or subindex not taken from bytes 2 to 4");

   property p_ack_zero;
      tx_valid_o && tx_data_o[7:0] == CMD_WR_ACK
         |-> tx_data_o[63:32] == 32'h00000000;
   endproperty
   a_ack_zero: assert property (p_ack_zero)
      else $error("write acknowledge payload not zero");

   property p_rd8;
      tx_valid_o && tx_data_o[7:0] == CMD_RD8
         |-> tx_data_o[63:40] == 24'h000000;
   endproperty
   a_rd8: assert property (p_rd8)
      else $error("8-bit read answer upper bytes not zero");

endmodule

// ### csso_od_model.sv
`timescale 1ns/1ps
// ==========================================================
// object dictionary model: objects 0x6000..0x6007, sub 1
module csso_od_model (
   // clock and pacing
   input  wire logic        core_clk_i,
   input  wire logic        slow_i,
   // lookup and commit from the server
   input  wire logic        od_req_i,
   input  wire logic [15:0] od_index_i,
   input  wire logic [7:0]  od_sub_i,
   input  wire logic        od_wr_i,
   input  wire logic [31:0] od_wdata_i,
   // lookup answer
   output logic             od_ack_o,
   output logic             od_exist_o,
   output logic             od_rw_o,
   output logic [1:0]       od_size_o,
   output logic [31:0]      od_rdata_o
);
   logic [31:0] mem_q [8];
   logic [1:0]  dly_q;
   logic [2:0]  k;

   assign k = od_index_i[2:0];

   // object size cycles through 16, 32 and 8 bit
   function automatic logic [1:0] sz(input logic [2:0] n);
      return 2'((32'(n) + 1) % 3);
   endfunction

   // preset contents and idle outputs
   initial begin
      for (int n = 0; n < 8; n++) begin
         mem_q[n] = {4{8'(8'h11 * (n + 1))}};
      end
      dly_q = 2'h0;
      {od_ack_o, od_exist_o, od_rw_o, od_size_o} = 5'h0A;
      od_rdata_o = 32'h5A5A5A5A;
   end

   // answer lookups, fast or slow; scramble outputs between answers
   always @(posedge core_clk_i) begin
      if (od_ack_o) begin
         od_ack_o <= 1'b0;
         dly_q    <= slow_i ? 2'h3 : 2'h0;
      end else if (od_req_i && dly_q != 2'h0) begin
         dly_q <= dly_q - 2'h1;
      end else if (od_req_i) begin
         od_ack_o   <= 1'b1;
         od_exist_o <= od_index_i[15:3] == 13'h0C00 && od_sub_i == 8'h01;
         od_rw_o    <= k < 3'h5;
         od_size_o  <= sz(k);
         od_rdata_o <= mem_q[k];
      end
      if (!od_ack_o && !(od_req_i && dly_q == 2'h0)) begin
         od_exist_o <= ~od_exist_o;
         od_rw_o    <= ~od_rw_o;
         od_size_o  <= ~od_size_o;
         od_rdata_o <= ~od_rdata_o;
      end
      if (od_wr_i) begin
         mem_q[k] <= od_wdata_i;
      end
   end
endmodule

// ### test_canopen_startup_sdo_server.sv
`timescale 1ns/1ps
module test_canopen_startup_sdo_server;
   import csso_pkg::*;
   localparam int unsigned TC = 4;
   localparam int unsigned IT = 3;

   // ==========================================================
   // signals
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] node_sw_i = 8'h02;
   logic [3:0] rate_sw_i = 4'h4;
   logic auto_rate_i = 1'b0, det_valid_i = 1'b0;
   logic [3:0] det_rate_i = 4'h0;
   logic nmt_start_i = 1'b0, nmt_preop_i = 1'b0;
   logic nmt_stop_i = 1'b0, nmt_reset_i = 1'b0;
   logic rx_valid_i = 1'b0, rx_ide_i = 1'b0;
   logic [10:0] rx_id_i = 11'h0;
   logic [3:0] rx_dlc_i = 4'h0;
   logic [63:0] rx_data_i = 64'h0;
   logic tx_valid_o, tx_ready_i = 1'b0, slow_i = 1'b0;
   logic [10:0] tx_id_o;
   logic [3:0] tx_dlc_o;
   logic [63:0] tx_data_o;
   logic od_req_o, od_ack_i, od_exist_i, od_rw_i, od_wr_o;
   logic [15:0] od_index_o;
   logic [7:0] od_sub_o;
   logic [1:0] od_size_i;
   logic [31:0] od_rdata_i, od_wdata_o;
   csso_nmt_e nmt_state_o;
   logic [6:0] node_id_o, node;
   logic [3:0] bitrate_o;
   logic emcy_req_o, pdo_en_o, pdo_send_all_o;
   logic [31:0] mem [8];
   logic [7:0] cmds [5] = '{CMD_WR8, CMD_WR16, CMD_WR32, CMD_RD_REQ, 8'h77};
   int err_count = 0, cmp_count = 0;

   csso_top #(.TICK_CYC(TC), .INIT_TICKS(IT)) csso_top_i (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .node_sw_i(node_sw_i),
      .rate_sw_i(rate_sw_i), .auto_rate_i(auto_rate_i),
      .det_valid_i(det_valid_i), .det_rate_i(det_rate_i),
      .nmt_start_i(nmt_start_i), .nmt_preop_i(nmt_preop_i),
      .nmt_stop_i(nmt_stop_i), .nmt_reset_i(nmt_reset_i),
      .rx_valid_i(rx_valid_i), .rx_ide_i(rx_ide_i), .rx_id_i(rx_id_i),
      .rx_dlc_i(rx_dlc_i), .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o),
      .tx_ready_i(tx_ready_i), .tx_id_o(tx_id_o), .tx_dlc_o(tx_dlc_o),
      .tx_data_o(tx_data_o), .od_req_o(od_req_o), .od_index_o(od_index_o),
      .od_sub_o(od_sub_o), .od_ack_i(od_ack_i), .od_exist_i(od_exist_i),
      .od_rw_i(od_rw_i), .od_size_i(od_size_i), .od_rdata_i(od_rdata_i),
      .od_wr_o(od_wr_o), .od_wdata_o(od_wdata_o),
      .nmt_state_o(nmt_state_o), .node_id_o(node_id_o),
      .bitrate_o(bitrate_o), .emcy_req_o(emcy_req_o), .pdo_en_o(pdo_en_o),
      .pdo_send_all_o(pdo_send_all_o));
   csso_od_model csso_od_model_i (
      .core_clk_i(core_clk_i), .slow_i(slow_i), .od_req_i(od_req_o),
      .od_index_i(od_index_o), .od_sub_i(od_sub_o), .od_wr_i(od_wr_o),
      .od_wdata_i(od_wdata_o), .od_ack_o(od_ack_i),
      .od_exist_o(od_exist_i), .od_rw_o(od_rw_i), .od_size_o(od_size_i),
      .od_rdata_o(od_rdata_i));

   // clock, 100 ns period
   initial forever #50 core_clk_i = ~core_clk_i;

   // ==========================================================
   // helpers
   task automatic tick();
      @(posedge core_clk_i);
      #1;
   endtask

   task automatic chk(input string nm, input logic [63:0] e, g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_of_test();
      if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   function automatic logic [31:0] msk(input logic [1:0] s);
      return s == SZ8 ? 32'hFF : s == SZ16 ? 32'hFFFF : 32'hFFFFFFFF;
   endfunction

   // expected answer frame; keeps the mirror of the objects current
   function automatic logic [63:0] exp_resp(input logic [7:0] c,
      input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] v);
      logic [2:0] k;
      logic [1:0] s;
      logic wr;
      k = ix[2:0];
      s = 2'((32'(k) + 1) % 3);
      wr = c == CMD_WR8 || c == CMD_WR16 || c == CMD_WR32;
      if (!wr && c != CMD_RD_REQ) return {ABT_BAD_CMD, sb, ix, CMD_ABORT};
      if (ix[15:3] != 13'h0C00 || sb != 8'h01)
         return {ABT_NO_OBJECT, sb, ix, CMD_ABORT};
      if (wr && k >= 3'h5) return {ABT_READ_ONLY, sb, ix, CMD_ABORT};
      if (wr) begin
         mem[k] = v;
         return {32'h0, sb, ix, CMD_WR_ACK};
      end
      return {mem[k] & msk(s), sb, ix,
              s == SZ8 ? CMD_RD8 : s == SZ16 ? CMD_RD16 : CMD_RD32};
   endfunction

   // offer one frame, then take the answer after a random stall
   task automatic sdo(input logic [10:0] id, input logic [3:0] dl,
      input logic ide, input logic [63:0] d, input logic ans,
      input logic [63:0] e);
      int n;
      {rx_id_i, rx_dlc_i, rx_ide_i, rx_data_i} = {id, dl, ide, d};
      rx_valid_i = 1'b1;
      tick();
      rx_valid_i = 1'b0;
      n = 0;
      while (tx_valid_o !== 1'b1 && n < 12) begin
         tick();
         n++;
      end
      chk("tx_valid", 64'(ans), 64'(tx_valid_o));
      if (tx_valid_o === 1'b1) begin
         chk("od_wr", 64'(e[7:0] == CMD_WR_ACK), 64'(od_wr_o));
         repeat ($urandom_range(2)) tick();
         chk("tx_id", 64'(SDO_TX_BASE + 11'(node)), 64'(tx_id_o));
         chk("tx_dlc", 64'h8, 64'(tx_dlc_o));
         chk("tx_data", e, tx_data_o);
         tx_ready_i = 1'b1;
         tick();
         tx_ready_i = 1'b0;
         chk("tx_release", 64'h0, 64'(tx_valid_o));
      end
   endtask

   task automatic xfer(input logic [7:0] c, input logic [15:0] ix,
                       input logic [7:0] sb, input logic [31:0] v);
      logic [31:0] m;
      m = c == CMD_WR8 ? v & 32'hFF : c == CMD_WR16 ? v & 32'hFFFF : v;
      if (c == CMD_RD_REQ) m = 32'h0;
      sdo(SDO_RX_BASE + 11'(node), SDO_DLC, 1'b0, {m, sb, ix, c}, 1'b1,
          exp_resp(c, ix, sb, m));
   endtask

   task automatic nmt(input logic [3:0] v);
      {nmt_reset_i, nmt_start_i, nmt_preop_i, nmt_stop_i} = v;
      tick();
      {nmt_reset_i, nmt_start_i, nmt_preop_i, nmt_stop_i} = 4'h0;
   endtask

   // start-up by reset line or by node reset; a read is offered meanwhile
   task automatic boot(input logic hard, input logic [6:0] nd,
                       input logic au, input logic [3:0] er);
      int n;
      if (hard) begin
         rst_i = 1'b1;
         node_sw_i = {1'b0, nd};
         rate_sw_i = 4'($urandom_range(8));
         {auto_rate_i, det_valid_i, det_rate_i} = {au, au, er};
         repeat (16) tick();
         rst_i = 1'b0;
      end else begin
         nmt(4'h8);
         chk("reset_init", 64'(NMT_INIT), 64'(nmt_state_o));
      end
      node = nd;
      {rx_id_i, rx_dlc_i, rx_ide_i} = {SDO_RX_BASE + 11'(nd), SDO_DLC, 1'b0};
      rx_data_i = {32'h0, 8'h01, 16'h6000, CMD_RD_REQ};
      n = 0;
      while (nmt_state_o === NMT_INIT && n < 100) begin
         rx_valid_i = n == 2;
         tick();
         n++;
      end
      rx_valid_i = 1'b0;
      chk("init_len", 64'h1, 64'(n >= IT*TC - 1 && n <= IT*TC + 5));
      chk("preop", 64'(NMT_PREOP), 64'(nmt_state_o));
      chk("init_quiet", 64'h0, 64'(tx_valid_o));
      chk("emcy", 64'h1, 64'(emcy_req_o));
      chk("node", 64'(nd), 64'(node_id_o));
      chk("rate", 64'(au ? er : rate_sw_i), 64'(bitrate_o));
      chk("pdo_off", 64'h0, 64'(pdo_en_o));
      tick();
      chk("emcy_once", 64'h0, 64'(emcy_req_o));
   endtask

   task automatic rand_xfers(input int cnt);
      for (int i = 0; i < cnt; i++) begin
         slow_i = 1'($urandom_range(1));
         xfer(cmds[$urandom_range(4)], 16'h6000 + 16'($urandom_range(9)),
              $urandom_range(9) == 0 ? 8'h02 : 8'h01, $urandom);
      end
   endtask

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'hC2A5C48C));
      for (int n = 0; n < 8; n++) mem[n] = {4{8'(8'h11 * (n + 1))}};
      boot(1'b1, 7'h02, 1'b0, 4'h0);
      xfer(CMD_WR8, 16'h6002, 8'h01, 32'hFF);
      xfer(CMD_RD_REQ, 16'h6002, 8'h01, 32'h0);
      xfer(CMD_WR16, 16'h6000, 8'h01, 32'hBEEF);
      xfer(CMD_WR32, 16'h6001, 8'h01, 32'h89ABCDEF);
      xfer(CMD_RD_REQ, 16'h6000, 8'h01, 32'h0);
      xfer(CMD_RD_REQ, 16'h6001, 8'h01, 32'h0);
      xfer(CMD_WR16, 16'h6006, 8'h01, 32'h1234);
      xfer(CMD_RD_REQ, 16'h6006, 8'h01, 32'h0);
      xfer(CMD_RD_REQ, 16'h6009, 8'h01, 32'h0);
      xfer(8'h77, 16'h6001, 8'h01, 32'h0);
      for (int i = 0; i < 3; i++)
         sdo(SDO_RX_BASE + 11'(node) + 11'(i == 0),
             i == 1 ? 4'h7 : SDO_DLC, i == 2,
             {32'h0, 8'h01, 16'h6000, CMD_RD_REQ}, 1'b0, 64'h0);
      nmt(4'h1);
      chk("stop", 64'(NMT_STOP), 64'(nmt_state_o));
      sdo(SDO_RX_BASE + 11'(node), SDO_DLC, 1'b0,
          {32'h0, 8'h01, 16'h6000, CMD_RD_REQ}, 1'b0, 64'h0);
      nmt(4'h2);
      chk("back_preop", 64'(NMT_PREOP), 64'(nmt_state_o));
      chk("pdo_still_off", 64'h0, 64'(pdo_en_o));
      nmt(4'h4);
      chk("oper", 64'(NMT_OPER), 64'(nmt_state_o));
      chk("pdo_on", 64'h1, 64'(pdo_en_o));
      chk("send_all", 64'h1, 64'(pdo_send_all_o));
      tick();
      chk("send_once", 64'h0, 64'(pdo_send_all_o));
      nmt(4'h4);
      chk("send_again", 64'h0, 64'(pdo_send_all_o));
      rand_xfers(40);
      boot(1'b0, node, 1'b0, 4'h0);
      boot(1'b1, 7'($urandom_range(126) + 1), 1'b1, 4'($urandom));
      rand_xfers(10);
      end_of_test();
   end

   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge core_clk_i);
      err_count++;
      end_of_test();
   end
endmodule
